/* dac_guard_pkg.sv */
// shared constants and carriers for the dac output guard and trim block
package dac_guard_pkg;
   localparam int NUM_CH       = 4;
   localparam int DATA_W       = 16;
   localparam int OFFSET_W     = 8;
   localparam int FINE_W       = 6;
   localparam int RANGE_W      = 2;
   localparam int GPIO_W       = 2;
   localparam int GND_W        = 12;
   localparam int TRIM_W       = 20;

   // coarse range encodings
   localparam logic [1:0] RANGE_10V0   = 2'h0;
   localparam logic [1:0] RANGE_10V256 = 2'h1;
   localparam logic [1:0] RANGE_10V526 = 2'h2;

   // reset values
   localparam logic [7:0]  OFFSET_RST = 8'h00;
   localparam logic [5:0]  FINE_RST   = 6'h00;
   localparam logic [1:0]  RANGE_RST  = 2'h0;

   // field positions inside the trimmed code: offset carries 3 fraction bits
   localparam int FRAC_BITS    = 3;
   localparam int FINE_SHIFT   = 2;

   typedef enum logic [2:0] {
      GUARD_CLAMPED = 3'h1,
      GUARD_WAIT    = 3'h2,
      GUARD_LIVE    = 3'h4
   } guard_state_e;

   typedef struct packed {
      logic [RANGE_W-1:0]  range_sel;
      logic [FINE_W-1:0]   fine_gain;
      logic [OFFSET_W-1:0] offset;
   } ch_trim_s;

   typedef struct packed {
      logic amp_connect_gate;
      logic output_clamp_gate;
   } gate_s;
endpackage : dac_guard_pkg

/* dac_channel_trim.sv */
// per-channel digital offset, fine gain and ground compensation arithmetic
`timescale 1ns/100ps
`default_nettype none
module dac_channel_trim (
   input  wire logic                                   i_mclk,
   input  wire logic                                   i_sys_rst,
   input  wire logic [dac_guard_pkg::DATA_W-1:0]        i_code,
   input  wire dac_guard_pkg::ch_trim_s                 i_trim,
   input  wire logic                                   i_gnd_comp_en,
   input  wire logic signed [dac_guard_pkg::GND_W-1:0]  i_gnd_diff,
   output logic        [dac_guard_pkg::TRIM_W-1:0]       o_code,
   output logic        [dac_guard_pkg::RANGE_W-1:0]      o_range
);
   localparam int W = dac_guard_pkg::TRIM_W;
   logic signed [W-1:0] scaled;
   logic signed [W-1:0] fine;
   logic signed [W-1:0] ofs;
   logic signed [W-1:0] gnd;
   logic signed [W-1:0] code_q;
   logic signed [W-1:0] code_d;
   logic signed [2*W-1:0] prod;
   logic [dac_guard_pkg::RANGE_W-1:0] range_q;
   logic [dac_guard_pkg::RANGE_W-1:0] range_d;

   always_comb begin
      // code in eighths of an lsb, twos complement about midscale
      scaled = W'(signed'(i_code)) <<< dac_guard_pkg::FRAC_BITS;
      // half-lsb gain step applied at full scale ends, scaled by code
      fine   = W'(signed'(i_trim.fine_gain)) <<< dac_guard_pkg::FINE_SHIFT;
      // double width product, the 20-bit one overflows near full scale
      prod   = (2*W)'(fine) * (2*W)'(signed'(i_code));
      fine   = W'(prod >>> (dac_guard_pkg::DATA_W - 1));
      ofs    = W'(signed'(i_trim.offset));
      gnd    = i_gnd_comp_en ? W'(i_gnd_diff) : '0;
      code_d = scaled + fine + ofs + gnd;
      range_d = (i_trim.range_sel == dac_guard_pkg::RANGE_10V526) ? dac_guard_pkg::RANGE_10V526 :
                (i_trim.range_sel == dac_guard_pkg::RANGE_10V256) ? dac_guard_pkg::RANGE_10V256 :
                dac_guard_pkg::RANGE_10V0;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         code_q  <= '0;
         range_q <= dac_guard_pkg::RANGE_RST;
      end else begin
         code_q  <= code_d;
         range_q <= range_d;
      end
   end

   assign o_code  = code_q;
   assign o_range = range_q;
endmodule : dac_channel_trim
`default_nettype wire

/* dac_output_guard_and_trim.sv */
// output clamp sequencing, trims, gpio port and ground compensation for four channels
`timescale 1ns/100ps
`default_nettype none
module dac_output_guard_and_trim #(
   parameter int NUM_CH = dac_guard_pkg::NUM_CH
) (
   input  wire logic                                              i_mclk,
   input  wire logic                                              i_sys_rst,
   input  wire logic                                              i_supply_ok,
   input  wire logic                                              i_ext_reset_clamp_in_n,
   input  wire logic                                              i_data_wr,
   input  wire logic [1:0]                                        i_data_ch,
   input  wire logic [dac_guard_pkg::DATA_W-1:0]                  i_data,
   input  wire logic                                              i_trim_wr,
   input  wire logic [1:0]                                        i_trim_ch,
   input  wire dac_guard_pkg::ch_trim_s                           i_trim,
   input  wire logic                                              i_gnd_comp_en,
   input  wire logic [NUM_CH*dac_guard_pkg::GND_W-1:0]            i_gnd_diff,
   input  wire logic [dac_guard_pkg::GPIO_W-1:0]                  i_gpio_dir_out,
   input  wire logic [dac_guard_pkg::GPIO_W-1:0]                  i_gpio_set,
   input  wire logic [dac_guard_pkg::GPIO_W-1:0]                  i_gpio_pin_i,
   output logic      [dac_guard_pkg::GPIO_W-1:0]                  o_gpio_pin_o,
   output logic      [dac_guard_pkg::GPIO_W-1:0]                  o_gpio_pin_oe,
   output logic      [dac_guard_pkg::GPIO_W-1:0]                  o_gpio_readback,
   output logic                                                   o_supply_detect_out,
   output logic      [NUM_CH-1:0]                                 o_amp_connect_gate,
   output logic      [NUM_CH-1:0]                                 o_output_clamp_gate,
   output logic      [NUM_CH*dac_guard_pkg::TRIM_W-1:0]           o_channel_output,
   output logic      [NUM_CH*dac_guard_pkg::RANGE_W-1:0]          o_channel_range
);
   // channel index ports are two bits wide
   if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
      $error("NUM_CH must be 1 to 4");
   end

   typedef struct packed {
      dac_guard_pkg::guard_state_e           st;
      logic [1:0]                            sup_sync;
      logic [1:0]                            rst_sync;
      logic [dac_guard_pkg::GPIO_W-1:0]      gp_s1;
      logic [dac_guard_pkg::GPIO_W-1:0]      gp_s2;
      logic [dac_guard_pkg::GPIO_W-1:0]      gp_out;
      logic [dac_guard_pkg::GPIO_W-1:0]      gp_oe;
      logic                                  sup_out;
      logic [NUM_CH-1:0]                     amp;
      logic [NUM_CH-1:0]                     clamp;
      logic [NUM_CH*dac_guard_pkg::DATA_W-1:0] data;
      dac_guard_pkg::ch_trim_s [NUM_CH-1:0]  trim;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic   sup_ok;
   logic   ext_low;

   assign sup_ok  = s_q.sup_sync[1];
   assign ext_low = ~s_q.rst_sync[1];

   always_comb begin
      s_d = s_q;
      s_d.sup_sync = {s_q.sup_sync[0], i_supply_ok};
      s_d.rst_sync = {s_q.rst_sync[0], i_ext_reset_clamp_in_n};
      s_d.gp_s1    = i_gpio_pin_i;
      s_d.gp_s2    = s_q.gp_s1;
      s_d.sup_out  = sup_ok;
      s_d.gp_oe    = i_gpio_dir_out;
      s_d.gp_out   = i_gpio_set & i_gpio_dir_out;
      if (i_data_wr && 32'(i_data_ch) < NUM_CH) begin
         s_d.data[i_data_ch*dac_guard_pkg::DATA_W +: dac_guard_pkg::DATA_W] = i_data;
      end
      if (i_trim_wr && 32'(i_trim_ch) < NUM_CH) begin
         s_d.trim[i_trim_ch] = i_trim;
      end
      case (s_q.st)
         dac_guard_pkg::GUARD_CLAMPED: begin
            if (sup_ok && !ext_low) begin
               s_d.st = dac_guard_pkg::GUARD_WAIT;
            end
         end
         dac_guard_pkg::GUARD_WAIT: begin
            if (!sup_ok || ext_low) begin
               s_d.st = dac_guard_pkg::GUARD_CLAMPED;
            end else if (i_data_wr) begin
               s_d.st = dac_guard_pkg::GUARD_LIVE;
            end
         end
         dac_guard_pkg::GUARD_LIVE: begin
            if (!sup_ok || ext_low) begin
               s_d.st = dac_guard_pkg::GUARD_CLAMPED;
            end
         end
         default: s_d.st = dac_guard_pkg::GUARD_CLAMPED;
      endcase
      s_d.amp   = (s_d.st == dac_guard_pkg::GUARD_LIVE) ? '1 : '0;
      s_d.clamp = ~s_d.amp;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s_q       <= '0;
         s_q.st    <= dac_guard_pkg::GUARD_CLAMPED;
         s_q.clamp <= '1;
         for (int i = 0; i < NUM_CH; i++) begin
            s_q.trim[i] <= '{dac_guard_pkg::RANGE_RST, dac_guard_pkg::FINE_RST, dac_guard_pkg::OFFSET_RST};
         end
      end else begin
         s_q <= s_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         dac_channel_trim dac_channel_trim_inst (
            .i_mclk        (i_mclk),
            .i_sys_rst     (i_sys_rst),
            .i_code        (s_q.data[g*dac_guard_pkg::DATA_W +: dac_guard_pkg::DATA_W]),
            .i_trim        (s_q.trim[g]),
            .i_gnd_comp_en (i_gnd_comp_en),
            .i_gnd_diff    (i_gnd_diff[g*dac_guard_pkg::GND_W +: dac_guard_pkg::GND_W]),
            .o_code        (o_channel_output[g*dac_guard_pkg::TRIM_W +: dac_guard_pkg::TRIM_W]),
            .o_range       (o_channel_range[g*dac_guard_pkg::RANGE_W +: dac_guard_pkg::RANGE_W])
         );
      end
   endgenerate

   assign o_gpio_pin_o        = s_q.gp_out;
   assign o_gpio_pin_oe       = s_q.gp_oe;
   assign o_gpio_readback     = s_q.gp_s2;
   assign o_supply_detect_out = s_q.sup_out;
   assign o_amp_connect_gate  = s_q.amp;
   assign o_output_clamp_gate = s_q.clamp;
endmodule : dac_output_guard_and_trim
`default_nettype wire

/* dac_guard_props.sv */
// port assertions for the dac output guard block
`timescale 1ns/100ps
`default_nettype none
module dac_guard_props #(
   parameter int NUM_CH = 4
) (
   input wire logic                     i_mclk,
   input wire logic                     i_sys_rst,
   input wire logic                     i_supply_ok,
   input wire logic                     i_ext_reset_clamp_in_n,
   input wire logic                     i_data_wr,
   input wire logic                     i_trim_wr,
   input wire logic [1:0]               i_trim_ch,
   input wire dac_guard_pkg::ch_trim_s  i_trim,
   input wire logic [1:0]               i_gpio_pin_i,
   input wire logic [1:0]               o_gpio_readback,
   input wire logic                     o_supply_detect_out,
   input wire logic [NUM_CH-1:0]        o_amp_connect_gate,
   input wire logic [NUM_CH-1:0]        o_output_clamp_gate,
   input wire logic [NUM_CH*2-1:0]      o_channel_range
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   chk_gate_excl: assert property (o_amp_connect_gate == ~o_output_clamp_gate)
      else $error("amp and clamp gates overlap");
   chk_brownout_clamp: assert property ($fell(i_supply_ok) |-> ##[1:4] &o_output_clamp_gate)
      else $error("no clamp after supply loss");
   chk_release_cause: assert property ($fell(o_output_clamp_gate[0]) |-> $past(i_data_wr) && o_supply_detect_out)
      else $error("clamp released without data write");
   chk_ext_clamp: assert property ($fell(i_ext_reset_clamp_in_n) |-> ##[1:4] &o_output_clamp_gate)
      else $error("no clamp after external reset");
   chk_ext_hold: assert property (!i_ext_reset_clamp_in_n [*5] |-> &o_output_clamp_gate)
      else $error("clamp dropped while external reset low");
   chk_detect_mirror: assert property ($stable(i_supply_ok) [*5] |-> o_supply_detect_out == i_supply_ok)
      else $error("supply detect output wrong");
   chk_pin_readback: assert property ($stable(i_gpio_pin_i) [*4] |-> o_gpio_readback == i_gpio_pin_i)
      else $error("gpio readback wrong");
   chk_range_load: assert property (i_trim_wr && i_trim_ch < NUM_CH ##2 1'b1 |->
      o_channel_range[$past(i_trim_ch, 2)*2 +: 2] == $past(i_trim.range_sel, 2))
      else $error("range not loaded");
   cov_release: cover property ($fell(o_output_clamp_gate[0]));
   cov_ext: cover property ($fell(i_ext_reset_clamp_in_n));
   cov_trim: cover property (i_trim_wr);
endmodule : dac_guard_props
bind dac_output_guard_and_trim dac_guard_props #(.NUM_CH(NUM_CH)) dac_guard_props_inst (.i_mclk, .i_sys_rst,
   .i_supply_ok, .i_ext_reset_clamp_in_n, .i_data_wr, .i_trim_wr, .i_trim_ch, .i_trim, .i_gpio_pin_i,
   .o_gpio_readback, .o_supply_detect_out, .o_amp_connect_gate, .o_output_clamp_gate, .o_channel_range);
`default_nettype wire

/* host_model.sv */
// host side: data writes and supervisor reset
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic        i_mclk,
   input  wire logic        i_go,
   input  wire logic [1:0]  i_ch,
   input  wire logic [15:0] i_word,
   input  wire logic        i_brown,
   output logic             o_data_wr,
   output logic [1:0]       o_data_ch,
   output logic [15:0]      o_data,
   output logic             o_rst_n
);
   always_ff @(posedge i_mclk) begin
      o_data_wr <= i_go;
      o_data_ch <= i_ch;
      o_data    <= i_go ? i_word : ~i_word;
      o_rst_n   <= ~i_brown;
   end
endmodule : host_model
`default_nettype wire

/* dac_output_guard_and_trim_tb.sv */
// self-checking bench for the dac guard block
`timescale 1ns/100ps
`default_nettype none
module dac_output_guard_and_trim_tb;
   typedef struct {int due; int kind; logic [19:0] v; int ch;} note_s;
   logic        clk = 1'b0, rst = 1'b1, sok = 1'b0, go = 1'b0, brown = 1'b0, twr = 1'b0, gce = 1'b0;
   logic [1:0]  tch = 2'h0, ch = 2'h0, dir = 2'h0, set = 2'h0, pin = 2'h0, dch, po, poe, rb;
   logic [15:0] word = 16'h0000, dat, d;
   logic [47:0] gnd = 48'h0;
   logic [5:0]  fv [2] = '{6'h20, 6'h1f};
   logic [3:0]  amp, clmp;
   logic [79:0] out;
   logic [7:0]  rng;
   logic        det, dwr, rst_n;
   int          fails = 0, cmp_count = 0, cyc = 0, seed = 32'ha10340a2, e;
   dac_guard_pkg::ch_trim_s trim = '0;
   note_s       q[$], n;
   host_model host_model_inst (.i_mclk(clk), .i_go(go), .i_ch(ch), .i_word(word), .i_brown(brown),
      .o_data_wr(dwr), .o_data_ch(dch), .o_data(dat), .o_rst_n(rst_n));
   dac_output_guard_and_trim dac_output_guard_and_trim_inst (.i_mclk(clk), .i_sys_rst(rst), .i_supply_ok(sok),
      .i_ext_reset_clamp_in_n(rst_n), .i_data_wr(dwr), .i_data_ch(dch), .i_data(dat), .i_trim_wr(twr),
      .i_trim_ch(tch), .i_trim(trim), .i_gnd_comp_en(gce), .i_gnd_diff(gnd), .i_gpio_dir_out(dir),
      .i_gpio_set(set), .i_gpio_pin_i(pin), .o_gpio_pin_o(po), .o_gpio_pin_oe(poe), .o_gpio_readback(rb),
      .o_supply_detect_out(det), .o_amp_connect_gate(amp), .o_output_clamp_gate(clmp),
      .o_channel_output(out), .o_channel_range(rng));
   always #12.5 clk = ~clk;
   task automatic note(int k, logic [19:0] v, int c = 0);
      q.push_back('{cyc + 6, k, v, c});
   endtask : note
   task automatic step(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task automatic wr(logic [1:0] c, logic [15:0] w);
      go = 1'b1;
      ch = c;
      word = w;
      step(1);
      go = 1'b0;
   endtask : wr
   task automatic tw(logic [1:0] c, dac_guard_pkg::ch_trim_s t);
      twr = 1'b1;
      tch = c;
      trim = t;
      step(1);
      twr = 1'b0;
   endtask : tw
   task automatic cmp_code(logic [19:0] s, logic [19:0] x);
      cmp_count++;
      if (s !== x) begin
         fails++;
         $display("FAIL channel_output exp %h got %h", x, s);
      end
   endtask : cmp_code
   task automatic cmp_bits(string nm, logic [3:0] s, logic [3:0] x);
      cmp_count++;
      if (s !== x) begin
         fails++;
         $display("FAIL %s exp %h got %h", nm, x, s);
      end
   endtask : cmp_bits
   task automatic final_report();
      $display("compared %0d, failed %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // outputs looked at mid-cycle, well away from the launching edge
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (q.size() != 0 && q[0].due <= cyc) begin
         n = q.pop_front();
         case (n.kind)
            0: cmp_code(out[n.ch*20 +: 20], n.v);
            1: cmp_bits("clamp", clmp, n.v[3:0]);
            2: cmp_bits("amp", amp, n.v[3:0]);
            3: cmp_bits("range", {2'h0, rng[n.ch*2 +: 2]}, n.v[3:0]);
            4: cmp_bits("pin_o", {2'h0, po}, n.v[3:0]);
            5: cmp_bits("pin_oe", {2'h0, poe}, n.v[3:0]);
            6: cmp_bits("readback", {2'h0, rb}, n.v[3:0]);
            default: cmp_bits("detect", {3'h0, det}, n.v[3:0]);
         endcase
      end
   end
   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      final_report();
   end
   initial begin
      step(2);
      rst = 1'b0;
      wr(2'h0, 16'h1234);
      note(1, 20'hf);
      step(8);
      sok = 1'b1;
      step(6);
      note(7, 20'h1);
      note(1, 20'hf);
      step(8);
      wr(2'h1, 16'h0100);
      note(1, 20'h0);
      note(0, 20'h00800, 1);
      step(8);
      $display("power-up test done");
      for (int r = 0; r < 3; r++) begin
         d = 16'($random(seed));
         tw(2'(r), '{2'(r), 6'h00, 8'($random(seed))});
         wr(2'(r), d);
         e = $signed(d) * 8 + $signed(trim.offset);
         note(0, 20'(e), r);
         note(3, 20'(r), r);
         step(8);
      end
      for (int i = 0; i < 2; i++) begin
         tw(2'h3, '{2'h0, fv[i], 8'h00});
         wr(2'h3, 16'h4000);
         note(0, 20'(131072 + $signed(fv[i]) * 2), 3);
         step(8);
      end
      tw(2'h0, '{2'h0, 6'h00, 8'h00});
      gce = 1'b1;
      gnd = {4{12'($random(seed))}};
      wr(2'h0, 16'h0000);
      note(0, 20'($signed(gnd[11:0])), 0);
      step(8);
      gce = 1'b0;
      $display("trim test done");
      for (int i = 0; i < 4; i++) begin
         dir = 2'(i);
         set = 2'($random(seed));
         pin = 2'($random(seed));
         step(1);
         note(4, 20'(set & dir));
         note(5, 20'(dir));
         note(6, 20'(pin));
         step(8);
      end
      $display("gpio test done");
      brown = 1'b1;
      step(6);
      wr(2'h1, 16'h0100);
      note(1, 20'hf);
      note(2, 20'h0);
      step(8);
      brown = 1'b0;
      step(6);
      wr(2'h1, 16'h0100);
      note(1, 20'h0);
      step(8);
      sok = 1'b0;
      step(6);
      note(1, 20'hf);
      note(7, 20'h0);
      step(8);
      $display("reset test done");
      final_report();
   end
endmodule : dac_output_guard_and_trim_tb
`default_nettype wire
